/* File: pkg/dcsu_pkg.sv */
package dcsu_pkg;

  // Page-0 command codes; all but read signal mode (0x0E) are handled by this unit
  localparam logic [7:0] CMD_NOP             = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET      = 8'h01;
  localparam logic [7:0] CMD_READ_LINK_ERR   = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS     = 8'h09;
  localparam logic [7:0] CMD_READ_SIGNAL_MODE = 8'h0E;

  // Error-count byte layout
  localparam int         ERR_CNT_W           = 7;
  localparam int         ERR_OVF_BIT         = 7;
  localparam logic [7:0] ERR_CNT_RESET       = 8'h00;

  // Status word bit positions
  localparam int ST_BOOSTER    = 31;
  localparam int ST_BGR        = 26;
  localparam int ST_SRC_RTL    = 24;
  localparam int ST_GATE_BTT   = 23;
  localparam int ST_IDLE       = 19;
  localparam int ST_SLEEP_OUT  = 17;
  localparam int ST_NORMAL     = 16;
  localparam int ST_INVERSION  = 13;
  localparam int ST_ALL_ON     = 12;
  localparam int ST_ALL_OFF    = 11;
  localparam int ST_DISP_ON    = 10;
  localparam int ST_TEAR_ON    = 9;
  localparam int ST_GAMMA_MSB  = 8;
  localparam int ST_GAMMA_LSB  = 6;
  localparam int ST_TEAR_MODE2 = 5;
  localparam int ST_PARITY     = 0;

  // Memory-access-control bit positions mirrored into the status word
  localparam int MAC_BGR_BIT   = 3;
  localparam int MAC_SRC_BIT   = 1;
  localparam int MAC_GATE_BIT  = 0;

  localparam logic [2:0] GAMMA_CURVE1 = 3'h0;

  // Response lengths in bytes
  localparam logic [2:0] RESP_LEN_ERR    = 3'h1;
  localparam logic [2:0] RESP_LEN_STATUS = 3'h4;

  // Timing
  localparam longint CLK_HZ           = 40_000_000;
  localparam longint RELOAD_TIME_MS   = 5;
  localparam longint SLEEP_IN_TIME_MS = 120;
  localparam int unsigned RELOAD_CYCLES_DFLT = int'((RELOAD_TIME_MS * CLK_HZ) / 1000);

  typedef enum logic [1:0] {
    CORE_IDLE   = 2'b00,
    CORE_RELOAD = 2'b01,
    CORE_RESP   = 2'b10
  } dcsu_core_state_t;

endpackage : dcsu_pkg

/* File: rtl/dcsu_toggle_sync.sv */
`timescale 1ns/10ps
module dcsu_toggle_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tog_in,
  output logic      pulse
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  // Two flops before any logic looks at the toggle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= tog_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign pulse = sync_r ^ prev_r;

endmodule : dcsu_toggle_sync

/* File: rtl/dcsu_top.sv */
// Contract
// - The no-operation command takes no parameter and changes no state, register or output apart from the frame_write_term_r pulse below.
// - A no-operation command during a frame write or frame write continue ends that write.
// - Soft reset returns every setting and parameter to its soft-reset default.
// - Soft reset blanks the display at once, before the default reload ends.
// - The device reloads all defaults within that 5 ms window.
// - Link errors are counted in the seven low bits of the error-count byte.
// - The top bit of the error-count byte sets on count overflow and stays set until cleared.
// - Once the error-count byte is fully returned, it and signal-mode bit zero clear to zero; an error in that cycle leaves a count of one and the bit set.
// - Status read returns four bytes, bits 31 down to 0, most significant first, undefined bits zero.
// - Booster, idle, sleep-out, inversion, display-on, tear-on, tear mode two and parity bits read one when active.
// - Status bits 26, 24, 23 mirror memory-access-control bits 3, 1, 0.
// - Bit 12 is all-pixels-on, bit 11 all-pixels-off, and normal bit 16 reads zero if either is on.
// - Gamma field bits 8 to 6 reads 000 for gamma curve one and no other value is reported.
`timescale 1ns/10ps
module dcsu_top
  import dcsu_pkg::*;
#(
  parameter int unsigned RELOAD_CYCLES = RELOAD_CYCLES_DFLT
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       link_clk,
  input  wire logic       link_cmd_valid,
  input  wire logic [7:0] link_cmd_code,
  input  wire logic       link_err,
  input  wire logic       link_parity_err,
  input  wire logic       link_rd_next,
  output logic            link_rd_valid_r,
  output logic [7:0]      link_rd_byte_r,
  input  wire logic       frame_write_busy,
  input  wire logic [3:0] memory_access_control,
  input  wire logic       booster_on,
  input  wire logic       idle_on,
  input  wire logic       inversion_on,
  input  wire logic       all_pixels_on,
  input  wire logic       all_pixels_off,
  input  wire logic       tear_sync_output_on,
  input  wire logic       tear_mode2,
  input  wire logic       sleep_out_set,
  input  wire logic       sleep_in_set,
  input  wire logic       display_on_set,
  input  wire logic       display_off_set,
  output logic            frame_write_term_r,
  output logic            soft_reset_r,
  output logic            reload_busy_r,
  output logic            display_blank_r,
  output logic            sleep_out_r,
  output logic            display_on_r,
  output logic            signal_mode_err_r,
  output logic [7:0]      link_error_count_r
);

  // Link-domain reset, released two link edges after rstn
  logic [1:0]       lrst_s;
  logic             lrstn;

  logic             lcmd_tog_r;
  logic [7:0]       lcmd_code_r;
  logic             lerr_tog_r;
  logic             lpar_tog_r;
  logic             ldone_tog_r;
  logic [2:0]       lrd_left_r;
  logic [31:0]      lrd_shift_r;
  logic             lresp_evt;

  dcsu_core_state_t state_r;
  logic [31:0]      reload_cnt_r;
  logic             resp_tog_r;
  logic [31:0]      resp_word_r;
  logic [2:0]       resp_len_r;
  logic             resp_is_err_r;
  logic             parity_err_r;
  logic [31:0]      status_word;
  logic             cmd_evt;
  logic             err_evt;
  logic             par_evt;
  logic             done_evt;
  logic             idle_cmd;
  logic             err_clear;

  always_ff @(posedge link_clk) begin
    lrst_s <= {lrst_s[0], rstn};
  end

  assign lrstn = lrst_s[1];

  // Link side: command bytes and error events become toggles for the core
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      lcmd_tog_r  <= 1'b0;
      lcmd_code_r <= CMD_NOP;
    end else if (link_cmd_valid) begin
      lcmd_tog_r  <= ~lcmd_tog_r;
      lcmd_code_r <= link_cmd_code;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      lerr_tog_r <= 1'b0;
      lpar_tog_r <= 1'b0;
    end else begin
      if (link_err) begin
        lerr_tog_r <= ~lerr_tog_r;
      end
      if (link_parity_err) begin
        lpar_tog_r <= ~lpar_tog_r;
      end
    end
  end

  dcsu_toggle_sync u_resp_sync (
    .clk    (link_clk),
    .rstn   (lrstn),
    .tog_in (resp_tog_r),
    .pulse  (lresp_evt)
  );

  // Read data leave MSB byte first; the core holds resp_word_r until done
  always_ff @(posedge link_clk) begin
    if (!lrstn) begin
      link_rd_valid_r <= 1'b0;
      link_rd_byte_r  <= 8'h00;
      lrd_left_r      <= 3'h0;
      lrd_shift_r     <= 32'h0000_0000;
      ldone_tog_r     <= 1'b0;
    end else if (lresp_evt) begin
      link_rd_valid_r <= 1'b1;
      link_rd_byte_r  <= resp_word_r[31:24];
      lrd_shift_r     <= resp_word_r;
      lrd_left_r      <= resp_len_r;
    end else if (link_rd_valid_r && link_rd_next) begin
      if (lrd_left_r == 3'h1) begin
        link_rd_valid_r <= 1'b0;
        link_rd_byte_r  <= 8'h00;
        lrd_left_r      <= 3'h0;
        ldone_tog_r     <= ~ldone_tog_r;
      end else begin
        link_rd_byte_r  <= lrd_shift_r[23:16];
        lrd_shift_r     <= {lrd_shift_r[23:0], 8'h00};
        lrd_left_r      <= lrd_left_r - 3'h1;
      end
    end
  end

  dcsu_toggle_sync u_cmd_sync (
    .clk    (clk),
    .rstn   (rstn),
    .tog_in (lcmd_tog_r),
    .pulse  (cmd_evt)
  );

  dcsu_toggle_sync u_err_sync (
    .clk    (clk),
    .rstn   (rstn),
    .tog_in (lerr_tog_r),
    .pulse  (err_evt)
  );

  dcsu_toggle_sync u_par_sync (
    .clk    (clk),
    .rstn   (rstn),
    .tog_in (lpar_tog_r),
    .pulse  (par_evt)
  );

  dcsu_toggle_sync u_done_sync (
    .clk    (clk),
    .rstn   (rstn),
    .tog_in (ldone_tog_r),
    .pulse  (done_evt)
  );

  // Commands are taken only when idle; a read in flight or a reload refuses them
  assign idle_cmd  = cmd_evt && (state_r == CORE_IDLE);
  assign err_clear = done_evt && (state_r == CORE_RESP) && resp_is_err_r;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_BOOSTER]   = booster_on;
    status_word[ST_IDLE]      = idle_on;
    status_word[ST_SLEEP_OUT] = sleep_out_r;
    status_word[ST_INVERSION] = inversion_on;
    status_word[ST_DISP_ON]   = display_on_r;
    status_word[ST_TEAR_ON]   = tear_sync_output_on;
    status_word[ST_TEAR_MODE2] = tear_mode2;
    status_word[ST_PARITY]    = parity_err_r;
    status_word[ST_BGR]       = memory_access_control[MAC_BGR_BIT];
    status_word[ST_SRC_RTL]   = memory_access_control[MAC_SRC_BIT];
    status_word[ST_GATE_BTT]  = memory_access_control[MAC_GATE_BIT];
    status_word[ST_ALL_ON]    = all_pixels_on;
    status_word[ST_ALL_OFF]   = all_pixels_off;
    status_word[ST_NORMAL]    = ~(all_pixels_on | all_pixels_off);
    status_word[ST_GAMMA_MSB:ST_GAMMA_LSB] = GAMMA_CURVE1;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= CORE_IDLE;
    end else begin
      case (state_r)
        CORE_IDLE: begin
          if (idle_cmd && lcmd_code_r == CMD_SOFT_RESET) begin
            state_r <= CORE_RELOAD;
          end else if (idle_cmd && (lcmd_code_r == CMD_READ_LINK_ERR || lcmd_code_r == CMD_READ_STATUS)) begin
            state_r <= CORE_RESP;
          end
        end
        CORE_RELOAD: begin
          if (reload_cnt_r == RELOAD_CYCLES - 32'd1) begin
            state_r <= CORE_IDLE;
          end
        end
        CORE_RESP: begin
          if (done_evt) begin
            state_r <= CORE_IDLE;
          end
        end
        default: begin
          state_r <= CORE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || state_r != CORE_RELOAD) begin
      reload_cnt_r <= 32'h0000_0000;
    end else begin
      reload_cnt_r <= reload_cnt_r + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      soft_reset_r    <= 1'b0;
      reload_busy_r   <= 1'b0;
      display_blank_r <= 1'b0;
    end else begin
      soft_reset_r <= idle_cmd && lcmd_code_r == CMD_SOFT_RESET;
      if (idle_cmd && lcmd_code_r == CMD_SOFT_RESET) begin
        reload_busy_r   <= 1'b1;
        display_blank_r <= 1'b1;
      end else if (state_r == CORE_RELOAD && reload_cnt_r == RELOAD_CYCLES - 32'd1) begin
        reload_busy_r   <= 1'b0;
        display_blank_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      frame_write_term_r <= 1'b0;
    end else begin
      frame_write_term_r <= idle_cmd && lcmd_code_r == CMD_NOP && frame_write_busy;
    end
  end

  // Power and display modes; soft reset forces sleep-in and display off
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sleep_out_r  <= 1'b0;
      display_on_r <= 1'b0;
    end else if (idle_cmd && lcmd_code_r == CMD_SOFT_RESET) begin
      sleep_out_r  <= 1'b0;
      display_on_r <= 1'b0;
    end else if (state_r != CORE_RELOAD) begin
      if (sleep_in_set) begin
        sleep_out_r <= 1'b0;
      end else if (sleep_out_set) begin
        sleep_out_r <= 1'b1;
      end
      if (display_off_set) begin
        display_on_r <= 1'b0;
      end else if (display_on_set) begin
        display_on_r <= 1'b1;
      end
    end
  end

  // Error counter: an error in the clearing cycle is kept, counted from zero
  always_ff @(posedge clk) begin
    if (!rstn || (idle_cmd && lcmd_code_r == CMD_SOFT_RESET)) begin
      link_error_count_r <= ERR_CNT_RESET;
      signal_mode_err_r  <= 1'b0;
    end else if (err_clear) begin
      link_error_count_r <= {1'b0, {(ERR_CNT_W-1){1'b0}}, err_evt};
      signal_mode_err_r  <= err_evt;
    end else if (err_evt) begin
      link_error_count_r[ERR_CNT_W-1:0] <= link_error_count_r[ERR_CNT_W-1:0] + 7'd1;
      if (&link_error_count_r[ERR_CNT_W-1:0]) begin
        link_error_count_r[ERR_OVF_BIT] <= 1'b1;
      end
      signal_mode_err_r <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || (idle_cmd && lcmd_code_r == CMD_SOFT_RESET)) begin
      parity_err_r <= 1'b0;
    end else if (par_evt) begin
      parity_err_r <= 1'b1;
    end
  end

  // Snapshot taken at the command and held steady while the link shifts it out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      resp_tog_r    <= 1'b0;
      resp_word_r   <= 32'h0000_0000;
      resp_len_r    <= 3'h0;
      resp_is_err_r <= 1'b0;
    end else if (idle_cmd && lcmd_code_r == CMD_READ_LINK_ERR) begin
      resp_tog_r    <= ~resp_tog_r;
      resp_word_r   <= {link_error_count_r, 24'h00_0000};
      resp_len_r    <= RESP_LEN_ERR;
      resp_is_err_r <= 1'b1;
    end else if (idle_cmd && lcmd_code_r == CMD_READ_STATUS) begin
      resp_tog_r    <= ~resp_tog_r;
      resp_word_r   <= status_word;
      resp_len_r    <= RESP_LEN_STATUS;
      resp_is_err_r <= 1'b0;
    end
  end

endmodule : dcsu_top

/* File: verification/dcsu_chk.sv */
`timescale 1ns/10ps
module dcsu_chk #(
  parameter int unsigned RELOAD_CYCLES = 20
) (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       frame_write_busy,
  input wire logic       frame_write_term_r,
  input wire logic       soft_reset_r,
  input wire logic       reload_busy_r,
  input wire logic       display_blank_r,
  input wire logic       sleep_out_r,
  input wire logic       display_on_r,
  input wire logic       signal_mode_err_r,
  input wire logic [7:0] link_error_count_r
);
  logic [31:0] busy_cnt_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk) begin
    if (!rstn || !reload_busy_r)
      busy_cnt_r <= '0;
    else
      busy_cnt_r <= busy_cnt_r + 32'h1;
  end
  sequence blank_start_s;
    ##[0:2] (reload_busy_r && display_blank_r);
  endsequence
  sequence clear_both_s;
    (link_error_count_r == 8'h00) && !signal_mode_err_r;
  endsequence
  soft_blank_a: assert property (soft_reset_r |-> blank_start_s)
    else $error("blank not raised after soft reset");
  blank_track_a: assert property (display_blank_r == reload_busy_r)
    else $error("blank and reload differ");
  reload_len_a: assert property ($fell(reload_busy_r) |-> busy_cnt_r <= RELOAD_CYCLES && busy_cnt_r > 0)
    else $error("reload length wrong");
  sleep_in_a: assert property (reload_busy_r && $past(reload_busy_r) |-> !sleep_out_r && !display_on_r)
    else $error("not in sleep after soft reset");
  reset_clear_a: assert property ($rose(reload_busy_r) |-> ##[0:1] clear_both_s)
    else $error("error state kept over soft reset");
  err_step_a: assert property ($changed(link_error_count_r[6:0]) && link_error_count_r[6:0] > 7'h01
    |-> link_error_count_r[6:0] == $past(link_error_count_r[6:0]) + 7'h01) else $error("count step wrong");
  ovf_set_a: assert property ($past(link_error_count_r) == 8'h7f && link_error_count_r[6:0] == 7'h00
    && signal_mode_err_r |-> link_error_count_r[7]) else $error("overflow not flagged");
  ovf_keep_a: assert property ($fell(link_error_count_r[7]) |-> link_error_count_r[6:0] <= 7'h01)
    else $error("overflow dropped without clear");
  clear_pair_a: assert property ($fell(signal_mode_err_r) |-> clear_both_s)
    else $error("clears not together");
  term_cause_a: assert property (frame_write_term_r |-> $past(frame_write_busy) ##1 !frame_write_term_r)
    else $error("bad write termination");
endmodule : dcsu_chk

/* File: verification/dcsu_host.sv */
`timescale 1ns/10ps
module dcsu_host
  import dcsu_pkg::*;
#(
  parameter int unsigned RESET_WAIT = 16
) (
  input  wire logic  link_clk,
  input  wire logic  link_rd_valid_r,
  output logic       link_cmd_valid,
  output logic [7:0] link_cmd_code,
  output logic       link_err,
  output logic       link_parity_err,
  output logic       link_rd_next
);
  bit slow = 1'b0;
  initial begin
    link_cmd_valid = 1'b0;
    link_cmd_code = 8'h00;
    link_err = 1'b0;
    link_parity_err = 1'b0;
    link_rd_next = 1'b0;
  end
  task automatic send_cmd(input logic [7:0] code);
    @(negedge link_clk);
    link_cmd_valid = 1'b1;
    link_cmd_code = code;
    @(negedge link_clk);
    link_cmd_valid = 1'b0;
    // Released byte flips so a stale code never looks live
    link_cmd_code = ~code;
    if (code == CMD_SOFT_RESET)
      repeat (RESET_WAIT) @(negedge link_clk);
    repeat (2) @(negedge link_clk);
  endtask : send_cmd
  task automatic link_event(input bit parity);
    @(negedge link_clk);
    link_err = !parity;
    link_parity_err = parity;
    @(negedge link_clk);
    link_err = 1'b0;
    link_parity_err = 1'b0;
  endtask : link_event
  task automatic take_bytes(input int n);
    int got;
    got = 0;
    for (int k = 0; k < 64 && got < n; k++) begin
      @(negedge link_clk);
      link_rd_next = !(slow && k[0]);
      @(posedge link_clk);
      if (link_rd_valid_r && link_rd_next)
        got++;
    end
    @(negedge link_clk);
    link_rd_next = 1'b0;
    repeat (2) @(negedge link_clk);
  endtask : take_bytes
endmodule : dcsu_host

/* File: verification/display_cmd_status_unit_bench.sv */
`timescale 1ns/10ps
module display_cmd_status_unit_bench import dcsu_pkg::*;;
  localparam int unsigned RELOAD = 20;
  logic clk = 1'b0, rstn = 1'b0, link_clk = 1'b0;
  logic link_cmd_valid, link_err, link_parity_err, link_rd_next, link_rd_valid_r;
  logic [7:0] link_cmd_code, link_rd_byte_r, link_error_count_r;
  logic [3:0] memory_access_control = 4'h0;
  logic frame_write_busy = 0, booster_on = 0, idle_on = 0, inversion_on = 0, all_pixels_on = 0;
  logic all_pixels_off = 0, tear_sync_output_on = 0, tear_mode2 = 0;
  logic sleep_out_set = 0, sleep_in_set = 0, display_on_set = 0, display_off_set = 0;
  logic frame_write_term_r, soft_reset_r, reload_busy_r, display_blank_r;
  logic sleep_out_r, display_on_r, signal_mode_err_r;
  logic exp_sleep = 0, exp_disp = 0, exp_par = 0;
  logic [31:0] rnd = 32'hcd9c_4895;
  logic [7:0] exp_q[$];
  int err_count = 0, n_tests = 0, cyc = 0, term_cnt = 0, blank_cnt = 0, t0;
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  dcsu_top #(.RELOAD_CYCLES(RELOAD)) uut (.clk(clk), .rstn(rstn), .link_clk(link_clk),
    .link_cmd_valid(link_cmd_valid), .link_cmd_code(link_cmd_code), .link_err(link_err),
    .link_parity_err(link_parity_err), .link_rd_next(link_rd_next), .link_rd_valid_r(link_rd_valid_r),
    .link_rd_byte_r(link_rd_byte_r), .frame_write_busy(frame_write_busy),
    .memory_access_control(memory_access_control), .booster_on(booster_on), .idle_on(idle_on),
    .inversion_on(inversion_on), .all_pixels_on(all_pixels_on), .all_pixels_off(all_pixels_off),
    .tear_sync_output_on(tear_sync_output_on), .tear_mode2(tear_mode2), .sleep_out_set(sleep_out_set),
    .sleep_in_set(sleep_in_set), .display_on_set(display_on_set), .display_off_set(display_off_set),
    .frame_write_term_r(frame_write_term_r), .soft_reset_r(soft_reset_r), .reload_busy_r(reload_busy_r),
    .display_blank_r(display_blank_r), .sleep_out_r(sleep_out_r), .display_on_r(display_on_r),
    .signal_mode_err_r(signal_mode_err_r), .link_error_count_r(link_error_count_r));
  dcsu_host host (.link_clk(link_clk), .link_rd_valid_r(link_rd_valid_r), .link_cmd_valid(link_cmd_valid),
    .link_cmd_code(link_cmd_code), .link_err(link_err), .link_parity_err(link_parity_err),
    .link_rd_next(link_rd_next));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc++;
    term_cnt += (frame_write_term_r === 1'b1);
    blank_cnt += (display_blank_r === 1'b1);
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  always @(posedge link_clk) begin
    if (link_rd_valid_r === 1'b1 && link_rd_next) begin
      if (exp_q.size() == 0)
        check(link_rd_byte_r, 8'hxx, "extra byte");
      else
        check(link_rd_byte_r, exp_q.pop_front(), "read byte");
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic rd_status();
    logic [31:0] w;
    w = 32'h0;
    {w[ST_BOOSTER], w[ST_BGR], w[ST_SRC_RTL], w[ST_GATE_BTT]} = {booster_on, memory_access_control[3],
      memory_access_control[1], memory_access_control[0]};
    {w[ST_IDLE], w[ST_SLEEP_OUT], w[ST_NORMAL]} = {idle_on, exp_sleep, !(all_pixels_on || all_pixels_off)};
    {w[ST_INVERSION], w[ST_ALL_ON], w[ST_ALL_OFF], w[ST_DISP_ON]} = {inversion_on, all_pixels_on,
      all_pixels_off, exp_disp};
    {w[ST_TEAR_ON], w[ST_TEAR_MODE2], w[ST_PARITY]} = {tear_sync_output_on, tear_mode2, exp_par};
    for (int b = 3; b >= 0; b--)
      exp_q.push_back(w[b*8 +: 8]);
    host.send_cmd(CMD_READ_STATUS);
    host.take_bytes(4);
    check(32'(exp_q.size()), 32'h0, "status left");
  endtask : rd_status
  task automatic set_modes(input logic [3:0] m);
    @(negedge clk);
    {sleep_out_set, sleep_in_set, display_on_set, display_off_set} = m;
    @(negedge clk);
    {sleep_out_set, sleep_in_set, display_on_set, display_off_set} = 4'h0;
    exp_sleep = m[2] ? 1'b0 : (m[3] ? 1'b1 : exp_sleep);
    exp_disp = m[0] ? 1'b0 : (m[1] ? 1'b1 : exp_disp);
    repeat (4) @(negedge clk);
  endtask : set_modes
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge link_clk);
    check(link_error_count_r, 8'h00, "count at reset");
    rd_status();
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      @(negedge clk);
      {booster_on, idle_on, inversion_on, all_pixels_on, all_pixels_off} = rnd[4:0];
      {tear_sync_output_on, tear_mode2, memory_access_control} = rnd[10:5];
      set_modes(rnd[14:11]);
      host.slow = i[0];
      rd_status();
    end
    $display("status test done");
    repeat (130) host.link_event(1'b0);
    host.link_event(1'b1);
    exp_par = 1'b1;
    repeat (8) @(negedge clk);
    check(link_error_count_r, 8'h82, "count wrapped");
    check(signal_mode_err_r, 1'b1, "mode err");
    exp_q.push_back(8'h82);
    host.send_cmd(CMD_READ_LINK_ERR);
    host.take_bytes(1);
    repeat (8) @(negedge clk);
    check(link_error_count_r, 8'h00, "count cleared");
    check(signal_mode_err_r, 1'b0, "mode err cleared");
    rd_status();
    $display("error count test done");
    // Busy level is random but the two no-ops see opposite levels, so exactly one ends a write
    rnd = lfsr(rnd);
    @(negedge clk);
    frame_write_busy = rnd[0];
    t0 = term_cnt;
    host.send_cmd(CMD_NOP);
    repeat (8) @(negedge clk);
    check(term_cnt - t0, frame_write_busy, "terminations");
    frame_write_busy = !rnd[0];
    host.send_cmd(CMD_NOP);
    repeat (8) @(negedge clk);
    check(term_cnt - t0, 1, "terminations idle");
    rd_status();
    $display("no-op test done");
    set_modes(4'ha);
    repeat (3) host.link_event(1'b0);
    t0 = blank_cnt;
    host.send_cmd(CMD_SOFT_RESET);
    check(blank_cnt - t0 > 0 && blank_cnt - t0 <= RELOAD, 1'b1, "blank time");
    check({sleep_out_r, display_on_r, link_error_count_r}, 10'h000, "soft defaults");
    {exp_sleep, exp_disp, exp_par} = 3'h0;
    rd_status();
    $display("soft reset test done");
    final_report();
  end
endmodule : display_cmd_status_unit_bench
bind dcsu_top dcsu_chk #(.RELOAD_CYCLES(RELOAD_CYCLES)) chk (.clk(clk), .rstn(rstn),
  .frame_write_busy(frame_write_busy), .frame_write_term_r(frame_write_term_r), .soft_reset_r(soft_reset_r),
  .reload_busy_r(reload_busy_r), .display_blank_r(display_blank_r), .sleep_out_r(sleep_out_r),
  .display_on_r(display_on_r), .signal_mode_err_r(signal_mode_err_r), .link_error_count_r(link_error_count_r));
